// *** hdl/jqc_pkg.sv ***
// Shared constants, types and decode functions for the quick-configuration link
package jqc_pkg;

   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;

   // Registers held by the converter end
   localparam logic [10:0] REG_LANE_RATE_CONTROL  = 11'h56e;
   localparam logic [10:0] REG_LINK_QUICK_CONFIG  = 11'h570;
   localparam int unsigned LRC_LOW_RATE_BIT       = 4;
   localparam logic [7:0]  LRC_RST                = 8'h00;
   localparam logic [7:0]  QC_RST                 = 8'h00;
   localparam logic [7:0]  RD_UNMAPPED            = 8'h00;

   // Controller registers on the AHB-Lite side, byte offsets
   localparam logic [4:0]  CTL_OFS_CMD    = 5'h00;
   localparam logic [4:0]  CTL_OFS_ADDR   = 5'h04;
   localparam logic [4:0]  CTL_OFS_WDATA  = 5'h08;
   localparam logic [4:0]  CTL_OFS_STATUS = 5'h0c;
   localparam logic [4:0]  CTL_OFS_PLAN   = 5'h10;
   localparam int unsigned CMD_GO_BIT     = 0;
   localparam int unsigned CMD_WRITE_BIT  = 1;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_DONE_BIT    = 1;
   localparam int unsigned ST_RANGE_BIT   = 2;
   localparam int unsigned ST_LLR_BIT     = 3;
   localparam int unsigned ST_WARN_BIT    = 4;
   localparam int unsigned ST_K_BIT       = 5;
   localparam int unsigned ST_RDATA_LSB   = 8;
   localparam int unsigned PLAN_DLOG_LSB  = 16;
   localparam int unsigned PLAN_K_LSB     = 24;
   localparam int unsigned PLAN_MODE_LSB  = 30;
   localparam logic [31:0] W1C_MASK       = 32'h0000_003e;

   // Lane rate arithmetic, rates in Mbps and MSPS
   localparam logic [31:0] LANE_MULT      = 32'd10;
   localparam logic [31:0] RATE_MIN_MBPS  = 32'd3125;
   localparam logic [31:0] RATE_LLR_MBPS  = 32'd6250;
   localparam logic [31:0] RATE_MAX_MBPS  = 32'd12500;

   // Multiframe length limits
   localparam logic [5:0]  K_MAX          = 6'd32;
   localparam logic [5:0]  K_ALIGN_MASK   = 6'h03;
   localparam logic [5:0]  KMIN_F1        = 6'd20;
   localparam logic [5:0]  KMIN_F2        = 6'd12;
   localparam logic [5:0]  KMIN_F4        = 6'd8;
   localparam logic [5:0]  KMIN_F8        = 6'd4;

   // Resolution and control-bit figures per word set
   localparam logic [3:0]  N_W8           = 4'd8;
   localparam logic [3:0]  N_DOWNCONV     = 4'd14;
   localparam logic [3:0]  N_REQUANT      = 4'd9;
   localparam logic [4:0]  NP_8           = 5'd8;
   localparam logic [4:0]  NP_16          = 5'd16;
   localparam logic [1:0]  CS_W8          = 2'd1;
   localparam logic [1:0]  CS_DOWNCONV    = 2'd1;
   localparam logic [1:0]  CS_REQUANT     = 2'd2;

   typedef enum logic [1:0] {
      JQC_MODE_W8          = 2'h0,
      JQC_MODE_DOWNCONV_IQ = 2'h1,
      JQC_MODE_REQUANT     = 2'h2
   } jqc_mode_e;

   typedef struct packed {
      logic       ok;
      logic [2:0] l;
      logic [3:0] m;
      logic [4:0] f;
      logic [3:0] s;
      logic       hd;
      logic [3:0] n;
      logic [4:0] np;
      logic [1:0] cs;
   } jqc_params_s;

   localparam jqc_params_s PARAMS_RST = '{ok: 1'b1, l: 3'd1, m: 4'd1, f: 5'd1, s: 4'd1,
                                          hd: 1'b0, n: N_W8, np: NP_8, cs: CS_W8};

   function automatic jqc_params_s jqc_entry(input logic [2:0] l, input logic [3:0] m,
                                             input logic [4:0] f, input logic [3:0] s,
                                             input logic [3:0] n, input logic [4:0] np,
                                             input logic [1:0] cs);
      jqc_params_s p;
      p = '{ok: 1'b1, l: l, m: m, f: f, s: s, hd: 1'b0, n: n, np: np, cs: cs};
      return p;
   endfunction

   // Unlisted code in the selected mode returns ok low
   function automatic jqc_params_s jqc_decode(input jqc_mode_e mode, input logic [7:0] code);
      jqc_params_s p;
      p = '0;
      unique case (mode)
         JQC_MODE_W8: begin
            unique case (code)
               8'h00: p = jqc_entry(3'd1, 4'd1, 5'd1, 4'd1, N_W8, NP_8, CS_W8);
               8'h01: p = jqc_entry(3'd1, 4'd1, 5'd2, 4'd2, N_W8, NP_8, CS_W8);
               8'h40: p = jqc_entry(3'd2, 4'd1, 5'd1, 4'd2, N_W8, NP_8, CS_W8);
               8'h41: p = jqc_entry(3'd2, 4'd1, 5'd2, 4'd4, N_W8, NP_8, CS_W8);
               8'h42: p = jqc_entry(3'd2, 4'd1, 5'd4, 4'd8, N_W8, NP_8, CS_W8);
               8'h80: p = jqc_entry(3'd4, 4'd1, 5'd1, 4'd4, N_W8, NP_8, CS_W8);
               8'h81: p = jqc_entry(3'd4, 4'd1, 5'd2, 4'd8, N_W8, NP_8, CS_W8);
               8'h09: p = jqc_entry(3'd1, 4'd2, 5'd2, 4'd1, N_W8, NP_8, CS_W8);
               8'h48: p = jqc_entry(3'd2, 4'd2, 5'd1, 4'd1, N_W8, NP_8, CS_W8);
               8'h49: p = jqc_entry(3'd2, 4'd2, 5'd2, 4'd2, N_W8, NP_8, CS_W8);
               8'h88: p = jqc_entry(3'd4, 4'd2, 5'd1, 4'd2, N_W8, NP_8, CS_W8);
               8'h89: p = jqc_entry(3'd4, 4'd2, 5'd2, 4'd4, N_W8, NP_8, CS_W8);
               8'h8a: p = jqc_entry(3'd4, 4'd2, 5'd4, 4'd8, N_W8, NP_8, CS_W8);
               default: p = '0;
            endcase
         end
         JQC_MODE_DOWNCONV_IQ: begin
            unique case (code)
               8'h1c: p = jqc_entry(3'd1, 4'd8, 5'd16, 4'd1, N_DOWNCONV, NP_16, CS_DOWNCONV);
               8'h5b: p = jqc_entry(3'd2, 4'd8, 5'd8, 4'd1, N_DOWNCONV, NP_16, CS_DOWNCONV);
               default: p = '0;
            endcase
         end
         JQC_MODE_REQUANT: begin
            unique case (code)
               8'h49: p = jqc_entry(3'd2, 4'd2, 5'd2, 4'd1, N_REQUANT, NP_16, CS_REQUANT);
               8'h88: p = jqc_entry(3'd4, 4'd2, 5'd1, 4'd1, N_REQUANT, NP_16, CS_REQUANT);
               default: p = '0;
            endcase
         end
         default: p = '0;
      endcase
      return p;
   endfunction

   function automatic logic [15:0] jqc_fout(input logic [15:0] fs_msps,
                                            input logic [2:0] dlog);
      return fs_msps >> dlog;
   endfunction

   // Lane count is 1, 2 or 4, so the divide is a shift
   function automatic logic [31:0] jqc_lane_rate(input jqc_params_s p, input logic [15:0] fout);
      logic [31:0] r;
      r = 32'(fout) * LANE_MULT * 32'(p.m);
      if (p.l == 3'd4) begin
         r = r >> 2;
      end else if (p.l == 3'd2) begin
         r = r >> 1;
      end
      return r;
   endfunction

   function automatic logic [5:0] jqc_kmin(input logic [4:0] f);
      logic [5:0] k;
      unique case (f)
         5'd1:    k = KMIN_F1;
         5'd2:    k = KMIN_F2;
         5'd4:    k = KMIN_F4;
         default: k = KMIN_F8;
      endcase
      return k;
   endfunction

endpackage

// *** hdl/jqc_link_if.sv ***
// Register link between the controller and the converter's configuration end
`timescale 1ns/1ps
interface jqc_link_if;
   logic        req_valid;
   logic        req_ready;
   logic        req_write;
   logic [10:0] req_addr;
   logic [7:0]  req_wdata;
   logic        rsp_valid;
   logic        rsp_ready;
   logic [7:0]  rsp_rdata;

   modport dev (input req_valid, req_write, req_addr, req_wdata, rsp_ready,
                output req_ready, rsp_valid, rsp_rdata);
   modport ctl (output req_valid, req_write, req_addr, req_wdata, rsp_ready,
                input req_ready, rsp_valid, rsp_rdata);
endinterface

// *** hdl/jqc_buf.sv ***
// Two-entry valid/ready buffer, head always in slot 0
`timescale 1ns/1ps
module jqc_buf (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       in_valid,
   input  wire logic [jqc_pkg::DATA_W-1:0] in_data,
   output logic                            in_ready,
   output logic                            out_valid,
   output logic [jqc_pkg::DATA_W-1:0]      out_data,
   input  wire logic                       out_ready
);
   import jqc_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] d1;
      logic [1:0]        cnt;
      logic              rdy;
      logic              vld;
   } jqc_buf_s;

   jqc_buf_s s_ff;
   jqc_buf_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (s_ff.vld && out_ready) begin
         nxt_s.d0  = s_ff.d1;
         nxt_s.cnt = s_ff.cnt - 2'd1;
      end
      // Space is judged before the pop, so ready never depends on out_ready
      if (in_valid && s_ff.rdy) begin
         if (nxt_s.cnt == 2'd0) begin
            nxt_s.d0 = in_data;
         end else begin
            nxt_s.d1 = in_data;
         end
         nxt_s.cnt = nxt_s.cnt + 2'd1;
      end
      nxt_s.vld = (nxt_s.cnt != 2'd0);
      nxt_s.rdy = (nxt_s.cnt != 2'd2);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '{d0: '0, d1: '0, cnt: 2'd0, rdy: 1'b1, vld: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign in_ready  = s_ff.rdy;
   assign out_valid = s_ff.vld;
   assign out_data  = s_ff.d0;
endmodule

// *** hdl/jqc_dev.sv ***
// Converter end: quick-configuration registers and link parameter decode
`timescale 1ns/1ps

// Behaviour
// - Lane rate is ten M fout over L
// - Software keeps lane rate within 3.125-12.5 Gbps
// - At 6.25 Gbps or above clear low-rate bit
// - Below 6.25 Gbps low-rate mode expected enabled
// - K divisible by four, max 32, F-dependent minimum
// - Eight-bit set: N' 8, N 8, CS 1
// - One-converter eight-bit codes give L, F, S=L*F
// - Two-converter eight-bit codes give S=L*F/2
// - Sixteen-bit eight-converter codes 0x1C and 0x5B
// - Complex four-channel mode: eight converters, 14-bit samples
// - Requantizer mode: two converters, 9 bits, 0x49/0x88
module jqc_dev (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   jqc_link_if.dev                   link,
   input  wire jqc_pkg::jqc_mode_e   app_mode,
   input  wire logic [15:0]          adc_rate_msps,
   input  wire logic [2:0]           decim_log2,
   output jqc_pkg::jqc_params_s      link_params,
   output logic [15:0]               fout_msps,
   output logic [31:0]               lane_rate_mbps,
   output logic [5:0]                k_min,
   output logic                      low_rate_enable,
   output logic                      qc_invalid
);
   import jqc_pkg::*;

   typedef struct packed {
      logic [7:0]  lane_rate_control;
      logic [7:0]  link_quick_configuration;
      jqc_params_s params;
      logic [15:0] fout;
      logic [31:0] rate;
      logic [5:0]  kmin;
      logic        invalid;
      logic        refused;
   } jqc_dev_s;

   jqc_dev_s    s_ff;
   jqc_dev_s    nxt_s;
   logic        take;
   logic [7:0]  rd_val;
   jqc_params_s wr_dec;
   jqc_params_s cur_dec;

   assign take = link.req_valid && link.req_ready;

   always_comb begin
      nxt_s   = s_ff;
      rd_val  = RD_UNMAPPED;
      wr_dec  = jqc_decode(app_mode, link.req_wdata);
      if (link.req_addr == REG_LANE_RATE_CONTROL) begin
         rd_val = s_ff.lane_rate_control;
      end else if (link.req_addr == REG_LINK_QUICK_CONFIG) begin
         rd_val = s_ff.link_quick_configuration;
      end
      if (take && link.req_write) begin
         if (link.req_addr == REG_LANE_RATE_CONTROL) begin
            nxt_s.lane_rate_control = link.req_wdata;
         end else if (link.req_addr == REG_LINK_QUICK_CONFIG) begin
            // A code the mode cannot carry is not stored at all
            if (wr_dec.ok) begin
               nxt_s.link_quick_configuration = link.req_wdata;
            end
            nxt_s.refused = !wr_dec.ok;
         end
      end
      // Table covers eight-bit, complex four-channel and requantizer sets
      cur_dec = jqc_decode(app_mode, nxt_s.link_quick_configuration);
      // Refused write stays flagged until a good code lands
      nxt_s.invalid = !cur_dec.ok || nxt_s.refused;
      if (cur_dec.ok) begin
         nxt_s.params = cur_dec;
      end
      // Mode change can strand the stored code; parameters hold until fixed
      nxt_s.fout = jqc_fout(adc_rate_msps, decim_log2);
      nxt_s.rate = jqc_lane_rate(nxt_s.params, nxt_s.fout);
      nxt_s.kmin = jqc_kmin(nxt_s.params.f);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '{lane_rate_control: LRC_RST, link_quick_configuration: QC_RST,
                   params: PARAMS_RST, fout: '0, rate: '0, kmin: KMIN_F1, invalid: 1'b0,
                   refused: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Every taken request answers once; a stalled controller backs up here
   jqc_buf u_rsp_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (take),
      .in_data   (rd_val),
      .in_ready  (link.req_ready),
      .out_valid (link.rsp_valid),
      .out_data  (link.rsp_rdata),
      .out_ready (link.rsp_ready)
   );

   assign link_params     = s_ff.params;
   assign fout_msps       = s_ff.fout;
   assign lane_rate_mbps  = s_ff.rate;
   assign k_min           = s_ff.kmin;
   assign low_rate_enable = s_ff.lane_rate_control[LRC_LOW_RATE_BIT];
   assign qc_invalid      = s_ff.invalid;
endmodule

// *** hdl/jqc_ctl.sv ***
// Controller end: AHB-Lite slave registers that issue checked link accesses
`timescale 1ns/1ps
module jqc_ctl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   jqc_link_if.ctl          link
);
   import jqc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ  = 3'b010,
      ST_RSP  = 3'b100
   } jqc_ctl_st_e;

   typedef struct packed {
      jqc_ctl_st_e st;
      logic        dp_wr;
      logic [4:0]  dp_ofs;
      logic        cmd_write;
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [15:0] fs;
      logic [2:0]  dlog;
      logic [5:0]  k;
      logic [1:0]  mode;
      logic [7:0]  shadow_qc;
      logic [7:0]  shadow_lrc;
      logic [5:1]  sticky;
      logic [31:0] rd;
      logic        req_valid;
      logic        req_write;
      logic [10:0] req_addr;
      logic [7:0]  req_wdata;
      logic        rsp_ready;
   } jqc_ctl_s;

   jqc_ctl_s    s_ff;
   jqc_ctl_s    nxt_s;
   logic        aphase;
   logic        go;
   logic        is_qc;
   logic        is_lrc;
   logic [7:0]  qc_new;
   logic [7:0]  lrc_new;
   jqc_params_s chk;
   logic [31:0] rate;
   logic        rng_bad;
   logic        llr_bad;
   logic        llr_warn;
   logic        k_bad;

   function automatic logic [31:0] ctl_read(input jqc_ctl_s s, input logic [4:0] ofs);
      logic [31:0] v;
      v = '0;
      unique case (ofs)
         CTL_OFS_CMD:    v[CMD_WRITE_BIT] = s.cmd_write;
         CTL_OFS_ADDR:   v[10:0] = s.addr;
         CTL_OFS_WDATA:  v[7:0] = s.wdata;
         CTL_OFS_STATUS: begin
            v[5:1]                           = s.sticky;
            v[ST_BUSY_BIT]                   = (s.st != ST_IDLE);
            v[ST_RDATA_LSB +: 8]             = s.rdata;
         end
         CTL_OFS_PLAN:   v = {s.mode, s.k, 5'h00, s.dlog, s.fs};
         default:        v = '0;
      endcase
      return v;
   endfunction

   assign aphase = hsel && htrans[1] && hready;

   always_comb begin
      nxt_s    = s_ff;
      go       = 1'b0;
      nxt_s.dp_wr  = aphase && hwrite;
      nxt_s.dp_ofs = haddr[4:0];
      if (s_ff.dp_wr) begin
         unique case (s_ff.dp_ofs)
            CTL_OFS_CMD: begin
               nxt_s.cmd_write = hwdata[CMD_WRITE_BIT];
               go              = hwdata[CMD_GO_BIT];
            end
            CTL_OFS_ADDR:   nxt_s.addr = hwdata[10:0];
            CTL_OFS_WDATA:  nxt_s.wdata = hwdata[7:0];
            CTL_OFS_STATUS: nxt_s.sticky = s_ff.sticky & ~hwdata[5:1];
            CTL_OFS_PLAN: begin
               nxt_s.fs   = hwdata[15:0];
               nxt_s.dlog = hwdata[PLAN_DLOG_LSB +: 3];
               nxt_s.k    = hwdata[PLAN_K_LSB +: 6];
               nxt_s.mode = hwdata[PLAN_MODE_LSB +: 2];
            end
            default: ;
         endcase
      end
      // Checks see address and data as they stand before this beat, but the write bit written in this beat
      is_qc    = s_ff.addr == REG_LINK_QUICK_CONFIG;
      is_lrc   = s_ff.addr == REG_LANE_RATE_CONTROL;
      qc_new   = (is_qc && nxt_s.cmd_write) ? s_ff.wdata : s_ff.shadow_qc;
      lrc_new  = (is_lrc && nxt_s.cmd_write) ? s_ff.wdata : s_ff.shadow_lrc;
      chk      = jqc_decode(jqc_mode_e'(s_ff.mode), qc_new);
      rate     = jqc_lane_rate(chk, jqc_fout(s_ff.fs, s_ff.dlog));
      rng_bad  = chk.ok && (rate < RATE_MIN_MBPS || rate > RATE_MAX_MBPS);
      llr_bad  = chk.ok && rate >= RATE_LLR_MBPS && lrc_new[LRC_LOW_RATE_BIT];
      llr_warn = chk.ok && rate < RATE_LLR_MBPS && !lrc_new[LRC_LOW_RATE_BIT];
      k_bad    = chk.ok && ((s_ff.k & K_ALIGN_MASK) != 6'h00 || s_ff.k > K_MAX
                            || s_ff.k < jqc_kmin(chk.f));
      unique case (s_ff.st)
         ST_IDLE: begin
            // Only writes to the two link registers are screened
            if (go && nxt_s.cmd_write && (is_qc || is_lrc)
                && (rng_bad || llr_bad || k_bad)) begin
               // Set wins over a clear in the same beat
               nxt_s.sticky[ST_RANGE_BIT] = s_ff.sticky[ST_RANGE_BIT] | rng_bad;
               nxt_s.sticky[ST_LLR_BIT]   = s_ff.sticky[ST_LLR_BIT] | llr_bad;
               nxt_s.sticky[ST_K_BIT]     = s_ff.sticky[ST_K_BIT] | k_bad;
               nxt_s.sticky[ST_DONE_BIT]  = 1'b1;
            end else if (go) begin
               if (nxt_s.cmd_write && (is_qc || is_lrc) && llr_warn) begin
                  nxt_s.sticky[ST_WARN_BIT] = 1'b1;
               end
               if (nxt_s.cmd_write && (is_qc || is_lrc)) begin
                  nxt_s.shadow_qc  = qc_new;
                  nxt_s.shadow_lrc = lrc_new;
               end
               nxt_s.req_valid = 1'b1;
               nxt_s.req_write = nxt_s.cmd_write;
               nxt_s.req_addr  = s_ff.addr;
               nxt_s.req_wdata = s_ff.wdata;
               nxt_s.st        = ST_REQ;
            end
         end
         ST_REQ: begin
            if (link.req_ready) begin
               nxt_s.req_valid = 1'b0;
               nxt_s.rsp_ready = 1'b1;
               nxt_s.st        = ST_RSP;
            end
         end
         ST_RSP: begin
            if (link.rsp_valid) begin
               nxt_s.rdata               = link.rsp_rdata;
               nxt_s.rsp_ready           = 1'b0;
               nxt_s.sticky[ST_DONE_BIT] = 1'b1;
               nxt_s.st                  = ST_IDLE;
            end
         end
         default: nxt_s.st = ST_IDLE;
      endcase
      // Read from the updated copy so a read right after a write sees it
      nxt_s.rd = aphase && !hwrite ? ctl_read(nxt_s, haddr[4:0]) : s_ff.rd;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_ff <= '{st: ST_IDLE, dp_wr: 1'b0, dp_ofs: '0, cmd_write: 1'b0, addr: '0,
                   wdata: '0, rdata: '0, fs: '0, dlog: '0, k: K_MAX, mode: JQC_MODE_W8,
                   shadow_qc: QC_RST, shadow_lrc: LRC_RST, sticky: '0, rd: '0,
                   req_valid: 1'b0, req_write: 1'b0, req_addr: '0, req_wdata: '0,
                   rsp_ready: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign hrdata         = s_ff.rd;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign link.req_valid = s_ff.req_valid;
   assign link.req_write = s_ff.req_write;
   assign link.req_addr  = s_ff.req_addr;
   assign link.req_wdata = s_ff.req_wdata;
   assign link.rsp_ready = s_ff.rsp_ready;
endmodule

// *** tb/jqc_props.sv ***
// Handshake checks on the controller-to-converter link
`timescale 1ns/1ps
module jqc_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_write,
   input wire logic [10:0] req_addr,
   input wire logic [7:0]  req_wdata,
   input wire logic        rsp_valid,
   input wire logic        rsp_ready,
   input wire logic [7:0]  rsp_rdata
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic take = req_valid && req_ready;

   chk_req_held: assert property (req_valid && !req_ready |=> req_valid
      && $stable({req_write, req_addr, req_wdata})) else $error("request changed early");
   chk_rsp_held: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_rdata)) else $error("response changed before popped");
   chk_rsp_next: assert property (take && !rsp_valid |=> rsp_valid)
      else $error("response late");
   chk_req_single: assert property (take |=> !req_valid)
      else $error("second request outstanding");
   chk_ready_after: assert property (take |=> rsp_ready)
      else $error("response not accepted");
   chk_pop_empty: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
      else $error("buffer not empty after pop");
   chk_rsp_bound: assert property (take |-> ##[1:4] (rsp_valid && rsp_ready))
      else $error("no response within four cycles");
   chk_rsp_cause: assert property ($rose(rsp_valid) |->
      $past(req_valid) && $past(req_ready)) else $error("response without request");
   chk_buf_room: assert property (!rsp_valid |-> req_ready)
      else $error("empty buffer refused request");
endmodule

// *** tb/testbench.sv ***
// Bench: AHB-Lite accesses through the controller to the converter end
`timescale 1ns/1ps
module testbench;
   import jqc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        low_rate_enable, qc_invalid;
   logic [31:0] haddr, hwdata, hrdata, lane_rate_mbps;
   logic [1:0]  htrans;
   logic [2:0]  hsize, decim_log2;
   logic [15:0] adc_rate_msps, fout_msps;
   logic [5:0]  k_min;
   jqc_mode_e   app_mode;
   jqc_params_s link_params;
   int          n_mismatch = 0;
   int          check_count = 0;
   // Code, mode, L, M, F, S; every entry runs at 8000 Mbps
   logic [31:0] code_tbl [17] = '{32'h0001_1011, 32'h0101_1022, 32'h4002_1012,
      32'h4102_1024, 32'h4202_1048, 32'h8004_1014, 32'h8104_1028, 32'h0901_2021,
      32'h4802_2011, 32'h4902_2022, 32'h8804_2012, 32'h8904_2024, 32'h8a04_2048,
      32'h1c11_8101, 32'h5b12_8081, 32'h4922_2021, 32'h8824_2011};
   // Rate, K, target, low-rate after, data, flags
   logic [47:0] row_tbl [11] = '{48'h01f4_20_0_0_00_12, 48'h01f4_20_1_1_10_02,
      48'h01f4_20_0_1_09_0a, 48'h0138_20_0_1_01_06, 48'h04e3_20_1_1_00_06,
      48'h0271_20_1_0_00_02, 48'h0271_10_0_0_00_22, 48'h0271_1e_0_0_00_22,
      48'h0271_24_0_0_00_22, 48'h0271_14_0_0_00_02, 48'h0271_20_0_0_55_02};
   jqc_link_if link ();
   jqc_ctl u_jqc_ctl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link(link.ctl));
   jqc_dev u_jqc_dev (.hclk, .hresetn, .link(link.dev), .app_mode, .adc_rate_msps,
      .decim_log2, .link_params, .fout_msps, .lane_rate_mbps, .k_min, .low_rate_enable,
      .qc_invalid);
   jqc_props u_jqc_props (.hclk, .hresetn, .req_valid(link.req_valid),
      .req_ready(link.req_ready), .req_write(link.req_write), .req_addr(link.req_addr),
      .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
      .rsp_rdata(link.rsp_rdata));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Each phase is held until hready is seen high
   task automatic ahb(input logic wr, input logic [4:0] ofs, input logic [31:0] wd,
      output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= {27'h0, ofs};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // Converter inputs follow the plan so both ends judge the same rate
   task automatic plan(input logic [15:0] fs, input logic [2:0] dl, input logic [5:0] k,
      input jqc_mode_e md);
      logic [31:0] x;
      app_mode <= md;
      adc_rate_msps <= fs;
      decim_log2 <= dl;
      ahb(1'b1, CTL_OFS_PLAN, {md, k, 5'h0, dl, fs}, x);
   endtask
   // Status is returned once done; sticky flags cleared after
   task automatic op(input logic wr, input logic [10:0] a, input logic [7:0] d,
      output logic [31:0] s);
      logic [31:0] x;
      ahb(1'b1, CTL_OFS_WDATA, {24'h0, d}, x);
      ahb(1'b1, CTL_OFS_ADDR, {21'h0, a}, x);
      ahb(1'b1, CTL_OFS_CMD, {30'h0, wr, 1'b1}, x);
      s = '0;
      for (int i = 0; i < 40 && s[ST_DONE_BIT] !== 1'b1; i++)
         ahb(1'b0, CTL_OFS_STATUS, 32'h0, s);
      ahb(1'b1, CTL_OFS_STATUS, W1C_MASK, x);
   endtask

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [31:0] e, st;
      logic [47:0] r;
      logic [15:0] fo;
      logic [2:0]  dl;
      hresetn = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      app_mode = JQC_MODE_W8;
      adc_rate_msps = 16'h0;
      decim_log2 = 3'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("reset params", 32'(link_params), 32'(PARAMS_RST));
      check("reset kmin", 32'(k_min), 32'd20);
      ahb(1'b0, CTL_OFS_PLAN, 32'h0, st);
      check("reset plan", st, 32'h2000_0000);
      ahb(1'b0, 5'h14, 32'h0, st);
      check("unmapped", st, 32'h0);
      check("hresp", {31'h0, hresp}, 32'h0);
      for (int i = 0; i < 3; i++) begin
         op(1'b0, i == 2 ? 11'h123 : REG_LANE_RATE_CONTROL + 11'(2 * i), 8'h00, st);
         check("reset read", {24'h0, st[15:8]}, 32'h0);
      end
      foreach (code_tbl[i]) begin
         e = code_tbl[i];
         fo = 16'(800 * e[19:16] / e[15:12]);
         dl = 3'(i % 3);
         plan(fo << dl, dl, 6'd32, jqc_mode_e'(e[21:20]));
         op(1'b1, REG_LINK_QUICK_CONFIG, e[31:24], st);
         check("flags", st & W1C_MASK, 32'h2);
         check("params", 32'(link_params), {4'h1, e[18:16], e[15:12], e[8:4], e[3:0], 1'b0,
            (e[20] ? 4'he : e[21] ? 4'h9 : 4'h8), (e[21:20] == 2'h0 ? 5'h08 : 5'h10),
            (e[21] ? 2'h2 : 2'h1)});
         check("fout", {16'h0, fout_msps}, {16'h0, fo});
         check("lane rate", lane_rate_mbps, 32'd8000);
         check("kmin", 32'(k_min), e[8:4] == 5'h1 ? 32'd20 : e[8:4] == 5'h2 ? 32'd12
            : e[8:4] == 5'h4 ? 32'd8 : 32'd4);
         check("invalid", {31'h0, qc_invalid}, 32'h0);
      end
      ahb(1'b0, CTL_OFS_PLAN, 32'h0, st);
      check("plan", st, 32'ha001_0c80);
      foreach (row_tbl[i]) begin
         r = row_tbl[i];
         plan(r[47:32], 3'h0, r[29:24], JQC_MODE_W8);
         op(1'b1, r[20] ? REG_LANE_RATE_CONTROL : REG_LINK_QUICK_CONFIG, r[15:8], st);
         check("screen", st & W1C_MASK, {24'h0, r[7:0]});
         check("low rate", {31'h0, low_rate_enable}, {31'h0, r[16]});
      end
      check("kept params", 32'(link_params), 32'(PARAMS_RST));
      check("invalid set", {31'h0, qc_invalid}, 32'h1);
      op(1'b0, REG_LINK_QUICK_CONFIG, 8'h00, st);
      check("kept code", {24'h0, st[15:8]}, 32'h0);
      conclude();
   end
endmodule
